//--- rtl/frg_pkg.sv
// package: register map, field layout and timing constants of the flash region guard
package frg_pkg;
  localparam int unsigned NUM_REGIONS  = 8;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned FADDR_W      = 32;
  localparam int unsigned DATA_W       = 32;
  // region block: base + index * stride
  localparam logic [11:0] REGION_BASE  = 12'h800;
  localparam logic [11:0] REGION_STRIDE = 12'h010;
  localparam logic [3:0]  OFS_START    = 4'h0;
  localparam logic [3:0]  OFS_SIZE     = 4'h4;
  localparam logic [3:0]  OFS_REGION_PERMISSION     = 4'h8;
  // interrupt registers
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h100;
  localparam logic [11:0] IRQ_MASK_OFS   = 12'h104;
  localparam logic [11:0] VIOL_ADDR_OFS  = 12'h108;
  localparam int unsigned IRQ_CORE_BIT   = 0;
  localparam int unsigned IRQ_DBG_BIT    = 1;
  localparam int unsigned IRQ_W          = 2;
  // permission field positions
  localparam int unsigned REGION_PERMISSION_WRITE_BIT = 1;
  localparam int unsigned REGION_PERMISSION_READ_BIT  = 2;
  // flash geometry
  localparam logic [31:0] FLASH_BASE     = 32'h0000_0000;
  localparam logic [31:0] FLASH_BYTES    = 32'h0004_0000;
  localparam logic [31:0] PAGE_MASK      = 32'h0000_0FFF;
  // protection becomes active this many cycles after configuration completes
  localparam int unsigned ARM_DELAY      = 2;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  // access kinds presented with each flash request
  typedef enum logic [1:0] {
    FRG_FETCH,
    FRG_READ,
    FRG_WRITE,
    FRG_ERASE
  } frg_kind_t;
endpackage

//--- rtl/frg_flash_region_guard.sv
// flash region guard: one-shot region configuration and access checking for core and debugger
//
// What this block does
// - read 0 write 0: region allows every access kind.
// - read 0 write 1: fetch and read allowed, write and erase refused.
// - read 1 write 0: write and erase allowed, fetch and read refused.
// - read 1 write 1: everything refused until next reset.
// - violating core access is blocked and raises a bus error.
// - region enforced two cycles after start, size and permission all written.
// - enforce only with page-aligned start, nonzero size and nonzero permission.
// - each configuration register takes one write (zero size or permission writes do not count); later writes ignored.
// - configuration clears only on device reset.
// - debugger read of read-protected region completes, returns zero.
// - debugger write to write-protected region is silently dropped.
`timescale 1ns/1ps
`default_nettype none
module frg_flash_region_guard (
  input  wire logic                       core_clk,      // cpu clock, 40 MHz
  input  wire logic                       rst,           // asynchronous device reset
  input  wire logic [11:0]                reg_addr,      // register byte offset
  input  wire logic [31:0]                reg_wdata,     // register write data
  input  wire logic                       reg_wr,        // register write strobe
  input  wire logic                       reg_rd,        // register read strobe
  output logic      [31:0]                reg_rdata,     // read data, cycle after strobe
  input  wire logic                       core_req,      // core flash request
  input  wire logic [31:0]                core_addr,     // core request address
  input  wire frg_pkg::frg_kind_t         core_kind,     // core request kind
  input  wire logic                       dbg_req,       // debugger flash request
  input  wire logic [31:0]                dbg_addr,      // debugger request address
  input  wire frg_pkg::frg_kind_t         dbg_kind,      // debugger request kind
  input  wire logic [31:0]                flash_rdata,   // data from flash for debugger
  output logic                            flash_req,     // request passed to flash
  output logic [31:0]                     flash_addr,    // address passed to flash
  output frg_pkg::frg_kind_t              flash_kind,    // kind passed to flash
  output logic                            flash_is_dbg,  // passed request came from debugger
  output logic                            core_bus_err,  // bus error pulse to core
  output logic                            dbg_done,      // debugger access answered
  output logic [31:0]                     dbg_rdata,     // debugger read data
  output logic                            irq            // level interrupt
);

  localparam int unsigned N = frg_pkg::NUM_REGIONS;

  // per-region configuration and written flags
  logic [31:0] start_q [N];
  logic [31:0] start_d [N];
  logic [31:0] size_q  [N];
  logic [31:0] size_d  [N];
  logic [2:0]  region_permission_q  [N];
  logic [2:0]  region_permission_d  [N];
  logic [2:0]  wrote_q [N];
  logic [2:0]  wrote_d [N];
  logic [1:0]  arm_q   [N];
  logic [1:0]  arm_d   [N];
  logic [N-1:0] active;
  logic [N-1:0] core_hit;
  logic [N-1:0] dbg_hit;

  // region decode of the register strobe
  logic        in_block;
  logic [2:0]  sel_idx;
  logic [3:0]  sel_ofs;
  assign in_block = (reg_addr >= frg_pkg::REGION_BASE)
                 && (reg_addr < 12'(frg_pkg::REGION_BASE + 12'(N) * frg_pkg::REGION_STRIDE));
  assign sel_idx  = reg_addr[6:4];
  assign sel_ofs  = reg_addr[3:0];

  // checks a request against one region's permission scheme
  function automatic logic refused(input logic [2:0] p, input frg_pkg::frg_kind_t k);
    logic rbit;
    logic wbit;
    rbit = p[frg_pkg::REGION_PERMISSION_READ_BIT];
    wbit = p[frg_pkg::REGION_PERMISSION_WRITE_BIT];
    case ({rbit, wbit})
      2'b00:   refused = 1'b0;
      2'b01:   refused = (k == frg_pkg::FRG_WRITE) || (k == frg_pkg::FRG_ERASE);
      2'b10:   refused = (k == frg_pkg::FRG_FETCH) || (k == frg_pkg::FRG_READ);
      default: refused = 1'b1;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_region
      logic wr_here;
      assign wr_here = reg_wr && in_block && (sel_idx == 3'(g));

      // one-shot capture of each configuration word
      always_comb begin
        start_d[g] = start_q[g];
        size_d[g]  = size_q[g];
        region_permission_d[g]  = region_permission_q[g];
        wrote_d[g] = wrote_q[g];
        if (wr_here && sel_ofs == frg_pkg::OFS_START && !wrote_q[g][0]) begin
          start_d[g]    = reg_wdata;
          wrote_d[g][0] = 1'b1;
        end
        // a zero size or permission write has no effect and keeps the slot open
        if (wr_here && sel_ofs == frg_pkg::OFS_SIZE && !wrote_q[g][1] && reg_wdata != 32'h0) begin
          size_d[g]     = reg_wdata;
          wrote_d[g][1] = 1'b1;
        end
        if (wr_here && sel_ofs == frg_pkg::OFS_REGION_PERMISSION && !wrote_q[g][2]
            && reg_wdata[2:1] != 2'h0) begin
          region_permission_d[g]     = {reg_wdata[2:1], 1'b0};
          wrote_d[g][2] = 1'b1;
        end
      end

      // arming delay: counts up once all three words are in
      always_comb begin
        arm_d[g] = arm_q[g];
        if (wrote_q[g] == 3'h7 && arm_q[g] != 2'(frg_pkg::ARM_DELAY)) begin
          arm_d[g] = arm_q[g] + 2'h1;
        end
      end

      // only the device reset clears configuration
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          start_q[g] <= frg_pkg::RESET_WORD;
          size_q[g]  <= frg_pkg::RESET_WORD;
          region_permission_q[g]  <= 3'h0;
          wrote_q[g] <= 3'h0;
          arm_q[g]   <= 2'h0;
        end else begin
          start_q[g] <= start_d[g];
          size_q[g]  <= size_d[g];
          region_permission_q[g]  <= region_permission_d[g];
          wrote_q[g] <= wrote_d[g];
          arm_q[g]   <= arm_d[g];
        end
      end

      // live only when armed, page aligned and nonzero
      assign active[g] = (arm_q[g] == 2'(frg_pkg::ARM_DELAY))
                      && ((start_q[g] & frg_pkg::PAGE_MASK) == 32'h0)
                      && (size_q[g] != 32'h0) && (region_permission_q[g] != 3'h0);
      // half-open window; 33-bit sum avoids wrap at the top of the map
      assign core_hit[g] = active[g] && refused(region_permission_q[g], core_kind)
                        && (core_addr >= start_q[g])
                        && ({1'b0, core_addr} < ({1'b0, start_q[g]} + {1'b0, size_q[g]}));
      assign dbg_hit[g]  = active[g] && refused(region_permission_q[g], dbg_kind)
                        && (dbg_addr >= start_q[g])
                        && ({1'b0, dbg_addr} < ({1'b0, start_q[g]} + {1'b0, size_q[g]}));
    end
  endgenerate

  logic core_viol;
  logic dbg_viol;
  assign core_viol = core_req && (|core_hit);
  assign dbg_viol  = !core_req && dbg_req && (|dbg_hit);

  // request path: core has priority; violators never reach flash
  logic               flash_req_d;
  logic [31:0]        flash_addr_d;
  frg_pkg::frg_kind_t flash_kind_d;
  logic               flash_is_dbg_d;
  logic               core_bus_err_d;
  logic               dbg_done_d;
  logic               dbg_zero_q;
  logic               dbg_pend_q;
  always_comb begin
    flash_req_d    = 1'b0;
    flash_addr_d   = 32'h0;
    flash_kind_d   = frg_pkg::FRG_FETCH;
    flash_is_dbg_d = 1'b0;
    core_bus_err_d = core_viol;
    dbg_done_d     = 1'b0;
    if (core_req && !core_viol) begin
      flash_req_d  = 1'b1;
      flash_addr_d = core_addr;
      flash_kind_d = core_kind;
    end else if (!core_req && dbg_req) begin
      if (dbg_viol) begin
        // refused debug accesses finish quietly: reads as zero, writes dropped
        dbg_done_d = 1'b1;
      end else begin
        flash_req_d    = 1'b1;
        flash_addr_d   = dbg_addr;
        flash_kind_d   = dbg_kind;
        flash_is_dbg_d = 1'b1;
      end
    end
  end

  // debug answer: passed and refused accesses both answer two edges after the request,
  // so back-to-back debug requests never collapse into one shared answer pulse
  logic [31:0] dbg_rdata_d;
  logic        dbg_done_out_d;
  always_comb begin
    dbg_done_out_d = dbg_zero_q || dbg_pend_q;
    dbg_rdata_d    = 32'h0;
    if (dbg_pend_q) begin
      dbg_rdata_d = flash_rdata;
    end
  end

  // interrupt status: set wins over a write-one clear in the same cycle
  logic [frg_pkg::IRQ_W-1:0] irq_stat_q;
  logic [frg_pkg::IRQ_W-1:0] irq_stat_d;
  logic [frg_pkg::IRQ_W-1:0] irq_mask_q;
  logic [frg_pkg::IRQ_W-1:0] irq_mask_d;
  logic [31:0]               viol_addr_q;
  logic [31:0]               viol_addr_d;
  always_comb begin
    irq_stat_d  = irq_stat_q;
    irq_mask_d  = irq_mask_q;
    viol_addr_d = viol_addr_q;
    if (reg_wr && reg_addr == frg_pkg::IRQ_STATUS_OFS) begin
      irq_stat_d = irq_stat_q & ~reg_wdata[frg_pkg::IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == frg_pkg::IRQ_MASK_OFS) begin
      irq_mask_d = reg_wdata[frg_pkg::IRQ_W-1:0];
    end
    if (core_viol) begin
      irq_stat_d[frg_pkg::IRQ_CORE_BIT] = 1'b1;
      viol_addr_d = core_addr;
    end
    if (dbg_viol) begin
      irq_stat_d[frg_pkg::IRQ_DBG_BIT] = 1'b1;
      viol_addr_d = dbg_addr;
    end
  end

  // register read mux; unmapped and reserved words read zero
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0;
    if (reg_rd) begin
      if (in_block) begin
        case (sel_ofs)
          frg_pkg::OFS_START: rdata_d = start_q[sel_idx];
          frg_pkg::OFS_SIZE:  rdata_d = size_q[sel_idx];
          frg_pkg::OFS_REGION_PERMISSION:  rdata_d = {29'h0, region_permission_q[sel_idx]};
          default:            rdata_d = 32'h0;
        endcase
      end else if (reg_addr == frg_pkg::IRQ_STATUS_OFS) begin
        rdata_d = {30'h0, irq_stat_q};
      end else if (reg_addr == frg_pkg::IRQ_MASK_OFS) begin
        rdata_d = {30'h0, irq_mask_q};
      end else if (reg_addr == frg_pkg::VIOL_ADDR_OFS) begin
        rdata_d = viol_addr_q;
      end
    end
  end

  // all outputs registered
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_req    <= 1'b0;
      flash_addr   <= 32'h0;
      flash_kind   <= frg_pkg::FRG_FETCH;
      flash_is_dbg <= 1'b0;
      core_bus_err <= 1'b0;
      dbg_done     <= 1'b0;
      dbg_rdata    <= 32'h0;
      dbg_pend_q   <= 1'b0;
      dbg_zero_q   <= 1'b0;
      irq_stat_q   <= 2'h0;
      irq_mask_q   <= 2'h0;
      viol_addr_q  <= 32'h0;
      reg_rdata    <= 32'h0;
      irq          <= 1'b0;
    end else begin
      flash_req    <= flash_req_d;
      flash_addr   <= flash_addr_d;
      flash_kind   <= flash_kind_d;
      flash_is_dbg <= flash_is_dbg_d;
      core_bus_err <= core_bus_err_d;
      dbg_done     <= dbg_done_out_d;
      dbg_rdata    <= dbg_rdata_d;
      dbg_pend_q   <= flash_req_d && flash_is_dbg_d;
      dbg_zero_q   <= dbg_done_d;
      irq_stat_q   <= irq_stat_d;
      irq_mask_q   <= irq_mask_d;
      viol_addr_q  <= viol_addr_d;
      reg_rdata    <= rdata_d;
      irq          <= |(irq_stat_d & irq_mask_d);
    end
  end

  // checks
  chk_core_blocked: assert property (@(posedge core_clk) disable iff (rst)
    core_viol |=> core_bus_err && !flash_req)
    else $error("violating core access reached flash");
  chk_core_passes: assert property (@(posedge core_clk) disable iff (rst)
    (core_req && !core_viol) |=> flash_req && !core_bus_err && flash_addr == $past(core_addr))
    else $error("legal core access not passed");
  chk_dbg_raz: assert property (@(posedge core_clk) disable iff (rst)
    dbg_viol |=> !flash_req ##1 (dbg_done && dbg_rdata == 32'h0))
    else $error("refused debug read not zero");
  chk_dbg_wi: assert property (@(posedge core_clk) disable iff (rst)
    (dbg_viol && (dbg_kind == frg_pkg::FRG_WRITE)) |=> !flash_req && !core_bus_err)
    else $error("refused debug write reached flash");
  chk_arm_delay: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(wrote_q[0] == 3'h7)) |-> !active[0] ##1 !active[0])
    else $error("region armed early");
  chk_one_shot: assert property (@(posedge core_clk) disable iff (rst)
    wrote_q[0][0] |=> $stable(start_q[0]))
    else $error("start written twice");
  chk_lock_all: assert property (@(posedge core_clk) disable iff (rst)
    (core_req && active[2] && region_permission_q[2][2:1] == 2'h3 && core_addr >= start_q[2]
     && core_addr < start_q[2] + size_q[2]) |=> core_bus_err)
    else $error("locked region accessed");
  chk_alignment: assert property (@(posedge core_clk) disable iff (rst)
    ((start_q[4] & frg_pkg::PAGE_MASK) != 32'h0) |-> !active[4])
    else $error("misaligned region active");
  chk_end_excl: assert property (@(posedge core_clk) disable iff (rst)
    (core_addr == start_q[0] + size_q[0]) |-> !core_hit[0])
    else $error("end address treated as inside");
  chk_arm_on_time: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(wrote_q[0] == 3'h7)) |-> ##2 (arm_q[0] == 2'(frg_pkg::ARM_DELAY)))
    else $error("region not armed on time");
  chk_size_once: assert property (@(posedge core_clk) disable iff (rst)
    wrote_q[0][1] |=> $stable(size_q[0]))
    else $error("size written twice");
  chk_region_permission_once: assert property (@(posedge core_clk) disable iff (rst)
    wrote_q[0][2] |=> $stable(region_permission_q[0]))
    else $error("permission written twice");
  // the refusal checks watch the regions that the bench sets up with those schemes
  chk_write_refused: assert property (@(posedge core_clk) disable iff (rst)
    (core_req && active[1] && region_permission_q[1][2:1] == 2'h1
     && (core_kind == frg_pkg::FRG_WRITE || core_kind == frg_pkg::FRG_ERASE)
     && core_addr >= start_q[1] && core_addr < start_q[1] + size_q[1]) |=> core_bus_err)
    else $error("write to write-protected region passed");
  chk_read_refused: assert property (@(posedge core_clk) disable iff (rst)
    (core_req && active[0] && region_permission_q[0][2:1] == 2'h2
     && (core_kind == frg_pkg::FRG_FETCH || core_kind == frg_pkg::FRG_READ)
     && core_addr >= start_q[0] && core_addr < start_q[0] + size_q[0]) |=> core_bus_err)
    else $error("read of read-protected region passed");
  cov_core_err: cover property (@(posedge core_clk) disable iff (rst) core_bus_err);
  cov_dbg_raz: cover property (@(posedge core_clk) disable iff (rst) dbg_viol);
  cov_armed: cover property (@(posedge core_clk) disable iff (rst) active[0]);
  cov_irq: cover property (@(posedge core_clk) disable iff (rst) irq);
  cov_dbg_pass: cover property (@(posedge core_clk) disable iff (rst) dbg_pend_q);

endmodule
`default_nettype wire

//--- verification/frg_flash_model.sv
// flash model: answers debugger reads with a word derived from the address
`timescale 1ns/1ps
`default_nettype none
module frg_flash_model (
  input  wire logic               core_clk,     // cpu clock
  input  wire logic               rst,          // device reset
  input  wire logic               flash_req,    // request passed by the guard
  input  wire logic [31:0]        flash_addr,   // request address
  input  wire frg_pkg::frg_kind_t flash_kind,   // request kind
  input  wire logic               flash_is_dbg, // request came from the debugger
  output logic      [31:0]        flash_rdata   // read data toward the guard
);
  logic [31:0] last_q;
  logic        hold_q;
  logic        live;
  // a debugger read is answered at once and held one cycle more
  assign live = flash_req && flash_is_dbg && (flash_kind == frg_pkg::FRG_READ);
  // idle line shows the inverse of the last word, so stale data never matches
  assign flash_rdata = live ? (flash_addr ^ 32'h5A5A_0000) : (hold_q ? last_q : ~last_q);
  // remember the last word; it toggles every idle cycle except the hold cycle after a debugger read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_q <= 32'h0000_0000;
      hold_q <= 1'b0;
    end else begin
      hold_q <= live;
      last_q <= flash_rdata;
    end
  end
endmodule
`default_nettype wire

//--- verification/frg_flash_region_guard_bench.sv
// self-checking bench for the flash region guard
`timescale 1ns/1ps
`default_nettype none
module frg_flash_region_guard_bench;
  logic               core_clk, rst, reg_wr, reg_rd, core_req, dbg_req;
  logic [11:0]        reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, core_addr, dbg_addr, flash_rdata;
  logic [31:0]        flash_addr, dbg_rdata;
  logic               flash_req, flash_is_dbg, core_bus_err, dbg_done, irq;
  frg_pkg::frg_kind_t core_kind, dbg_kind, flash_kind;
  int                 num_errors, checks;

  frg_flash_region_guard dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req),
    .core_addr(core_addr), .core_kind(core_kind), .dbg_req(dbg_req), .dbg_addr(dbg_addr),
    .dbg_kind(dbg_kind), .flash_rdata(flash_rdata), .flash_req(flash_req),
    .flash_addr(flash_addr), .flash_kind(flash_kind), .flash_is_dbg(flash_is_dbg),
    .core_bus_err(core_bus_err), .dbg_done(dbg_done), .dbg_rdata(dbg_rdata), .irq(irq));

  frg_flash_model flash (
    .core_clk(core_clk), .rst(rst), .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_kind(flash_kind), .flash_is_dbg(flash_is_dbg), .flash_rdata(flash_rdata));

  // 40 MHz cpu clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // register write: one strobe cycle, then a released cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // register read: data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // start, size and permission of one region, in that order
  task automatic cfg(input int n, input logic [31:0] s, input logic [31:0] z,
                     input logic [31:0] p);
    logic [11:0] b;
    b = frg_pkg::REGION_BASE + 12'(n) * frg_pkg::REGION_STRIDE;
    wr(b + 12'(frg_pkg::OFS_START), s);
    wr(b + 12'(frg_pkg::OFS_SIZE), z);
    wr(b + 12'(frg_pkg::OFS_REGION_PERMISSION), p);
  endtask

  // one flash access; now skips the launch edge to follow a write directly
  task automatic acc(input logic dbg, input logic [31:0] a, input frg_pkg::frg_kind_t k,
                     input logic ok, input logic now);
    if (!now) @(posedge core_clk);
    core_req <= !dbg;
    dbg_req <= dbg;
    core_addr <= a;
    dbg_addr <= a;
    core_kind <= k;
    dbg_kind <= k;
    @(posedge core_clk);
    core_req <= 1'b0;
    dbg_req <= 1'b0;
    #1 check(32'(flash_req), 32'(ok));
    check(32'(core_bus_err), 32'(!ok && !dbg));
    if (ok) check(flash_addr, a);
    if (ok) check(32'(flash_kind), 32'(k));
    if (ok) check(32'(flash_is_dbg), 32'(dbg));
    if (dbg) begin
      // every debug access, passed or refused, answers on the following edge
      @(posedge core_clk);
      #1 check(32'(dbg_done), 32'h1);
      if (k == frg_pkg::FRG_READ) check(dbg_rdata, ok ? (a ^ 32'h5A5A_0000) : 32'h0);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    #100us;
    num_errors++;
    final_report();
  end

  // main sequence
  initial begin
    {rst, reg_wr, reg_rd, core_req, dbg_req} = 5'h10;
    {reg_addr, reg_wdata, core_addr, dbg_addr} = '0;
    core_kind = frg_pkg::FRG_FETCH;
    dbg_kind = frg_pkg::FRG_FETCH;
    num_errors = 0;
    checks = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(12'h808, 32'h0000_0000);
    rd(12'h80C, 32'h0000_0000);
    acc(0, 32'h0000_1000, frg_pkg::FRG_WRITE, 1, 0);
    // boot code sets up page-multiple regions no larger than half the flash
    cfg(0, 32'h0000_1000, 32'h0000_1000, 32'h0000_0004);
    acc(0, 32'h0000_1000, frg_pkg::FRG_READ, 1, 1);
    repeat (2) @(posedge core_clk);
    acc(0, 32'h0000_1000, frg_pkg::FRG_READ, 0, 0);
    acc(0, 32'h0000_1FFC, frg_pkg::FRG_FETCH, 0, 0);
    acc(0, 32'h0000_1FFC, frg_pkg::FRG_WRITE, 1, 0);
    acc(0, 32'h0000_1000, frg_pkg::FRG_ERASE, 1, 0);
    acc(0, 32'h0000_2000, frg_pkg::FRG_READ, 1, 0);
    acc(0, 32'h0000_0FFC, frg_pkg::FRG_READ, 1, 0);
    acc(1, 32'h0000_1004, frg_pkg::FRG_READ, 0, 0);
    // second attempt at region 0 must leave the first words in place
    cfg(0, 32'h0000_6000, 32'h0000_2000, 32'h0000_0002);
    rd(12'h800, 32'h0000_1000);
    rd(12'h804, 32'h0000_1000);
    rd(12'h808, 32'h0000_0004);
    // region 1 write-protected
    cfg(1, 32'h0000_3000, 32'h0000_1000, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    acc(0, 32'h0000_3000, frg_pkg::FRG_FETCH, 1, 0);
    acc(0, 32'h0000_3004, frg_pkg::FRG_READ, 1, 0);
    acc(0, 32'h0000_3008, frg_pkg::FRG_WRITE, 0, 0);
    acc(0, 32'h0000_3FFC, frg_pkg::FRG_ERASE, 0, 0);
    acc(1, 32'h0000_3010, frg_pkg::FRG_WRITE, 0, 0);
    acc(1, 32'h0000_3010, frg_pkg::FRG_READ, 1, 0);
    // region 2 locked: every kind refused, with an idle cycle after each access
    cfg(2, 32'h0000_5000, 32'h0000_2000, 32'h0000_0006);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 4; i++) acc(0, 32'h0000_6FFC, frg_pkg::frg_kind_t'(i), 0, 0);
    acc(1, 32'h0000_5000, frg_pkg::FRG_READ, 0, 0);
    acc(1, 32'h0000_5000, frg_pkg::FRG_WRITE, 0, 0);
    // permission zero, misaligned start and zero size leave regions inactive
    cfg(3, 32'h0000_8000, 32'h0000_1000, 32'h0000_0000);
    cfg(4, 32'h0000_9010, 32'h0000_1000, 32'h0000_0006);
    cfg(5, 32'h0000_A000, 32'h0000_0000, 32'h0000_0006);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 4; i++) acc(0, 32'h0000_8000, frg_pkg::frg_kind_t'(i), 1, 0);
    acc(0, 32'h0000_9800, frg_pkg::FRG_READ, 1, 0);
    acc(0, 32'h0000_A000, frg_pkg::FRG_READ, 1, 0);
    // interrupt: both events pending, masked, then unmasked and cleared one by one
    rd(frg_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
    check(32'(irq), 32'h0);
    wr(frg_pkg::IRQ_MASK_OFS, 32'h0000_0003);
    @(posedge core_clk);
    #1 check(32'(irq), 32'h1);
    wr(frg_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
    rd(frg_pkg::IRQ_STATUS_OFS, 32'h0000_0002);
    check(32'(irq), 32'h1);
    wr(frg_pkg::IRQ_STATUS_OFS, 32'h0000_0002);
    @(posedge core_clk);
    #1 check(32'(irq), 32'h0);
    // a reset in mid-run is the only way to open the regions again
    do_reset();
    rd(12'h828, 32'h0000_0000);
    acc(0, 32'h0000_5000, frg_pkg::FRG_READ, 1, 0);
    final_report();
  end
endmodule
`default_nettype wire
